/* verilog/csd_store_decode.sv */
`include "csd_regs.svh"
`default_nettype none

module csd_store_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Instruction from fetch
    input wire logic instrValid,
    input wire logic [15:0] instr,
    // Mode and present extensions
    input wire logic capMode,
    input wire logic isRv64,
    input wire logic extCompressed,
    input wire logic extLegacy,
    input wire logic extPurecap,
    // Capability of the base register field
    input wire logic regTag,
    input wire logic regSealed,
    input wire logic regPermWrite,
    input wire logic [63:0] regCursor,
    input wire logic [63:0] regBase,
    input wire logic [63:0] regTop,
    // Capability stack pointer
    input wire logic spTag,
    input wire logic spSealed,
    input wire logic spPermWrite,
    input wire logic [63:0] spCursor,
    input wire logic [63:0] spBase,
    input wire logic [63:0] spTop,
    // Default data authority
    input wire logic ddcTag,
    input wire logic ddcSealed,
    input wire logic ddcPermWrite,
    input wire logic [63:0] ddcBase,
    input wire logic [63:0] ddcTop,
    // Decoded store to the load-store pipeline
    output logic outValid,
    output logic outIllegal,
    output csd_pkg::csd_kind_type outKind,
    output csd_pkg::csd_auth_type outAuth,
    output logic [63:0] outAddr,
    output logic [4:0] outSize,
    output logic [4:0] outBaseReg,
    output logic [4:0] outSrcReg,
    // Exception report
    output logic outFault,
    output logic [4:0] outCause,
    output logic [3:0] outFaultType,
    output logic outMisaligned
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Compressed three-bit register field maps to x8..x15
    function automatic logic [4:0] primeReg(input logic [2:0] field);
        primeReg = {`CSD_PRIME_HI, field};
    endfunction : primeReg

    // ****************************************************************
    // Decode
    // ****************************************************************

    logic [1:0] quad; // Quadrant of the encoding
    logic [2:0] funct3; // Slot within the quadrant
    logic legal; // Encoding is a store this core implements
    logic modeExt; // Extension needed by the current mode
    csd_pkg::csd_kind_type kind; // Decoded store kind
    csd_pkg::csd_form_type form; // Offset layout
    csd_pkg::csd_auth_type auth; // Authorising capability
    logic [9:0] offset; // Scaled offset
    logic [4:0] size; // Bytes written
    logic [63:0] addr; // Effective address
    logic authTag; // Selected capability fields
    logic authSealed;
    logic authPermWrite;
    logic [63:0] authBase;
    logic [63:0] authTop;
    logic [4:0] cause; // Check result
    logic misaligned; // Capability store alignment fault
    logic [3:0] alignMask; // Low address bits that must be zero

    assign quad = instr[`CSD_OPF];
    assign funct3 = instr[`CSD_F3];

    // Slot to kind; capability mode decodes the FSW slot (RV32) and the FSD slot (RV64) as CSC
    always_comb begin
        kind = csd_pkg::CSD_KIND_NONE;
        form = csd_pkg::CSD_FORM_W;
        modeExt = capMode ? extPurecap : extLegacy;
        unique case (funct3)
            `CSD_F3_WORD: begin
                kind = csd_pkg::CSD_KIND_SW;
            end
            `CSD_F3_DWORD: begin
                if (isRv64) begin
                    kind = csd_pkg::CSD_KIND_SD;
                    form = csd_pkg::CSD_FORM_D;
                end else if (capMode) begin
                    kind = csd_pkg::CSD_KIND_CSC;
                end else begin
                    kind = csd_pkg::CSD_KIND_FSW;
                end
            end
            `CSD_F3_DFP: begin
                if (isRv64 && capMode) begin
                    kind = csd_pkg::CSD_KIND_CSC;
                    form = csd_pkg::CSD_FORM_Q;
                end else begin
                    kind = csd_pkg::CSD_KIND_FSD;
                    form = csd_pkg::CSD_FORM_D;
                end
            end
            default: kind = csd_pkg::CSD_KIND_NONE;
        endcase
    end

    assign legal = extCompressed && modeExt && kind != csd_pkg::CSD_KIND_NONE
        && (quad == `CSD_OP_Q0 || quad == `CSD_OP_Q2);

    always_comb begin
        if (!capMode) begin
            auth = csd_pkg::CSD_AUTH_DDC;
        end else if (quad == `CSD_OP_Q2) begin
            auth = csd_pkg::CSD_AUTH_SP;
        end else begin
            auth = csd_pkg::CSD_AUTH_REG;
        end
    end

    // Select the authorising fields
    always_comb begin
        unique case (auth)
            csd_pkg::CSD_AUTH_SP: begin
                authTag = spTag;
                authSealed = spSealed;
                authPermWrite = spPermWrite;
                authBase = spBase;
                authTop = spTop;
            end
            csd_pkg::CSD_AUTH_DDC: begin
                authTag = ddcTag;
                authSealed = ddcSealed;
                authPermWrite = ddcPermWrite;
                authBase = ddcBase;
                authTop = ddcTop;
            end
            default: begin
                authTag = regTag;
                authSealed = regSealed;
                authPermWrite = regPermWrite;
                authBase = regBase;
                authTop = regTop;
            end
        endcase
    end

    // Access width per kind; the capability size follows XLEN
    always_comb begin
        unique case (kind)
            csd_pkg::CSD_KIND_SD, csd_pkg::CSD_KIND_FSD: size = `CSD_SZ_DWORD;
            csd_pkg::CSD_KIND_CSC: size = isRv64 ? `CSD_SZ_CAP64 : `CSD_SZ_CAP32;
            default: size = `CSD_SZ_WORD;
        endcase
    end

    csd_offset offsetUnit (
        .instr(instr),
        .form(form),
        .offset(offset)
    );

    assign addr = ((quad == `CSD_OP_Q2) ? spCursor : regCursor) + {54'h0, offset};

    csd_cap_check checkUnit (
        .tag(authTag),
        .sealed(authSealed),
        .permWrite(authPermWrite),
        .base(authBase),
        .top(authTop),
        .addr(addr),
        .size(size),
        .cause(cause)
    );

    assign alignMask = size[3:0] - 4'h1;
    assign misaligned = kind == csd_pkg::CSD_KIND_CSC && (addr[3:0] & alignMask) != 4'h0;

    // ****************************************************************
    // Output register
    // ****************************************************************

    logic next_outValid;
    logic next_outIllegal;
    logic next_outFault;
    logic [4:0] next_outCause;
    logic [3:0] next_outFaultType;
    logic next_outMisaligned;

    // Fault fields stay clear unless a legal store is presented
    always_comb begin
        next_outValid = instrValid && legal;
        next_outIllegal = instrValid && !legal;
        next_outFault = 1'h0;
        next_outCause = `CSD_CAUSE_NONE;
        next_outFaultType = `CSD_TYPE_NONE;
        next_outMisaligned = 1'h0;
        if (next_outValid) begin
            if (cause != `CSD_CAUSE_NONE) begin
                next_outFault = 1'h1;
                next_outCause = cause;
                next_outFaultType = `CSD_TYPE_DATA;
            // Capability faults outrank the alignment fault
            end else begin
                next_outMisaligned = misaligned;
            end
        end
    end

    // Registering keeps every output glitch free for the pipeline
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outValid <= 1'h0;
            outIllegal <= 1'h0;
            outKind <= csd_pkg::CSD_KIND_NONE;
            outAuth <= csd_pkg::CSD_AUTH_DDC;
            outAddr <= 64'h0;
            outSize <= 5'h00;
            outBaseReg <= 5'h00;
            outSrcReg <= 5'h00;
            outFault <= 1'h0;
            outCause <= `CSD_CAUSE_NONE;
            outFaultType <= `CSD_TYPE_NONE;
            outMisaligned <= 1'h0;
        end else begin
            outValid <= next_outValid;
            outIllegal <= next_outIllegal;
            outKind <= kind;
            outAuth <= auth;
            outAddr <= addr;
            outSize <= size;
            outBaseReg <= (quad == `CSD_OP_Q2) ? `CSD_REG_SP : primeReg(instr[`CSD_RS1P]);
            outSrcReg <= (quad == `CSD_OP_Q2) ? instr[`CSD_RS2] : primeReg(instr[`CSD_RS2P]);
            outFault <= next_outFault;
            outCause <= next_outCause;
            outFaultType <= next_outFaultType;
            outMisaligned <= next_outMisaligned;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic take; // A legal store is presented this cycle
    assign take = instrValid && legal;

    AST_WORD_SLOT: assert property (
        take && funct3 == `CSD_F3_WORD |=> outKind == csd_pkg::CSD_KIND_SW && outSize == 5'h04)
        else $error("word slot not decoded as word store");

    AST_REG_AUTH: assert property (
        take && capMode && quad == `CSD_OP_Q0 |=> outAuth == csd_pkg::CSD_AUTH_REG)
        else $error("register store not authorised by base register");

    AST_SP_FORM: assert property (
        take && quad == `CSD_OP_Q2 |=> outBaseReg == 5'h02 && outSrcReg == $past(instr[6:2]))
        else $error("stack store fields wrong");

    AST_LEGACY_DDC: assert property (
        instrValid && !capMode |=> outAuth == csd_pkg::CSD_AUTH_DDC)
        else $error("legacy store not authorised by default authority");

    AST_FAULT_TYPE: assert property (
        outFault |-> outValid && outFaultType == 4'h1 && outCause != 5'h00)
        else $error("fault without data type or cause");

    AST_TAG_FIRST: assert property (
        take && !authTag |=> outFault && outCause == 5'h01)
        else $error("tag violation not reported");

    AST_SEAL_PRIO: assert property (
        take && authTag && authSealed |=> outCause == 5'h02)
        else $error("seal violation priority wrong");

    AST_PERM: assert property (
        take && authTag && !authSealed && !authPermWrite |=> outCause == 5'h03)
        else $error("permission violation not reported");

    AST_RV32_SLOT: assert property (
        take && !isRv64 && funct3 == `CSD_F3_DWORD |=>
        outKind == ($past(capMode) ? csd_pkg::CSD_KIND_CSC : csd_pkg::CSD_KIND_FSW))
        else $error("RV32 111 slot decoded wrongly");

    AST_MISALIGN: assert property (
        outValid && !outFault && outKind == csd_pkg::CSD_KIND_CSC
        && outAddr[2:0] != 3'h0 |-> outMisaligned)
        else $error("misaligned capability store not flagged");

    AST_ILLEGAL: assert property (
        instrValid && !extCompressed ##1 1'b1 |-> outIllegal && !outValid)
        else $error("store decoded without compressed extension");

    COV_CAP_STORE: cover property (outValid && outKind == csd_pkg::CSD_KIND_CSC);
    COV_LEN_FAULT: cover property (outFault && outCause == 5'h04);
    COV_LEGACY_FSD: cover property (outValid && outKind == csd_pkg::CSD_KIND_FSD
        && outAuth == csd_pkg::CSD_AUTH_DDC);

endmodule : csd_store_decode

`default_nettype wire

/* verilog/csd_regs.svh */
`ifndef CSD_REGS_SVH
`define CSD_REGS_SVH

// ****************************************************************
// Instruction field slices
// ****************************************************************
`define CSD_OPF 1:0
`define CSD_F3 15:13
`define CSD_RS1P 9:7
`define CSD_RS2P 4:2
`define CSD_RS2 6:2

// Quadrant codes
`define CSD_OP_Q0 2'h0
`define CSD_OP_Q2 2'h2

// Store slots
`define CSD_F3_WORD 3'h6
`define CSD_F3_DWORD 3'h7
`define CSD_F3_DFP 3'h5

// Register-based offset pieces
`define CSD_Q0_OFF53 12:10
`define CSD_Q0_OFF54 12:11
`define CSD_Q0_OFF76 6:5
`define CSD_Q0_B2 6
`define CSD_Q0_B6 5
`define CSD_Q0_B8 10

// Stack-relative offset pieces
`define CSD_Q2_W52 12:9
`define CSD_Q2_W76 8:7
`define CSD_Q2_D53 12:10
`define CSD_Q2_D86 9:7
`define CSD_Q2_Q54 12:11
`define CSD_Q2_Q96 10:7

// ****************************************************************
// Registers, sizes, fault codes
// ****************************************************************
`define CSD_PRIME_HI 2'h1
`define CSD_REG_SP 5'h02
`define CSD_SZ_WORD 5'h04
`define CSD_SZ_DWORD 5'h08
`define CSD_SZ_CAP32 5'h08
`define CSD_SZ_CAP64 5'h10
`define CSD_CAUSE_NONE 5'h00
`define CSD_CAUSE_TAG 5'h01
`define CSD_CAUSE_SEAL 5'h02
`define CSD_CAUSE_PERM 5'h03
`define CSD_CAUSE_LEN 5'h04
`define CSD_TYPE_NONE 4'h0
`define CSD_TYPE_DATA 4'h1

`endif

/* verilog/csd_pkg.sv */
`default_nettype none

// ****************************************************************
// Shared types
// ****************************************************************
package csd_pkg;

    // Kind of store after decode
    typedef enum logic [2:0] {
        CSD_KIND_NONE,
        CSD_KIND_SW,
        CSD_KIND_SD,
        CSD_KIND_FSW,
        CSD_KIND_FSD,
        CSD_KIND_CSC
    } csd_kind_type;

    // Which capability authorises the access
    typedef enum logic [1:0] {
        CSD_AUTH_REG,
        CSD_AUTH_SP,
        CSD_AUTH_DDC
    } csd_auth_type;

    // Offset scaling layout
    typedef enum logic [1:0] {
        CSD_FORM_W,
        CSD_FORM_D,
        CSD_FORM_Q
    } csd_form_type;

endpackage : csd_pkg

`default_nettype wire

/* verilog/csd_offset.sv */
`include "csd_regs.svh"
`default_nettype none

// ****************************************************************
// Scaled offset extraction
// ****************************************************************
module csd_offset (
    // Instruction and layout
    input wire logic [15:0] instr,
    input wire csd_pkg::csd_form_type form,
    // Zero-extended byte offset
    output logic [9:0] offset
);

    // Offsets are unsigned and pre-scaled, so low bits are always zero
    always_comb begin
        offset = 10'h000;
        if (instr[`CSD_OPF] == `CSD_OP_Q0) begin
            unique case (form)
                csd_pkg::CSD_FORM_W: offset = {3'h0, instr[`CSD_Q0_B6],
                    instr[`CSD_Q0_OFF53], instr[`CSD_Q0_B2], 2'h0};
                csd_pkg::CSD_FORM_D: offset = {2'h0, instr[`CSD_Q0_OFF76],
                    instr[`CSD_Q0_OFF53], 3'h0};
                csd_pkg::CSD_FORM_Q: offset = {1'h0, instr[`CSD_Q0_B8],
                    instr[`CSD_Q0_OFF76], instr[`CSD_Q0_OFF54], 4'h0};
                default: offset = 10'h000;
            endcase
        end else begin
            unique case (form)
                csd_pkg::CSD_FORM_W: offset = {2'h0, instr[`CSD_Q2_W76],
                    instr[`CSD_Q2_W52], 2'h0};
                csd_pkg::CSD_FORM_D: offset = {1'h0, instr[`CSD_Q2_D86],
                    instr[`CSD_Q2_D53], 3'h0};
                csd_pkg::CSD_FORM_Q: offset = {instr[`CSD_Q2_Q96],
                    instr[`CSD_Q2_Q54], 4'h0};
                default: offset = 10'h000;
            endcase
        end
    end

endmodule : csd_offset

`default_nettype wire

/* verilog/csd_cap_check.sv */
`include "csd_regs.svh"
`default_nettype none

// ****************************************************************
// Authority capability checks
// ****************************************************************
module csd_cap_check (
    // Authorising capability
    input wire logic tag,
    input wire logic sealed,
    input wire logic permWrite,
    input wire logic [63:0] base,
    input wire logic [63:0] top,
    // Access
    input wire logic [63:0] addr,
    input wire logic [4:0] size,
    // Violation code, none when all pass
    output logic [4:0] cause
);

    // One past the last byte; 65 bits so a wrap is never in bounds
    logic [64:0] endAddr;

    // Fixed priority keeps a single cause per access
    // one cause, fixed order
    always_comb begin
        endAddr = {1'h0, addr} + {60'h0, size};
        if (!tag) begin
            cause = `CSD_CAUSE_TAG;
        end else if (sealed) begin
            cause = `CSD_CAUSE_SEAL;
        end else if (!permWrite) begin
            cause = `CSD_CAUSE_PERM;
        end else if (addr < base || endAddr > {1'h0, top}) begin
            cause = `CSD_CAUSE_LEN;
        end else begin
            cause = `CSD_CAUSE_NONE;
        end
    end

endmodule : csd_cap_check

`default_nettype wire

/* verif/csd_lsu_model.sv */
`default_nettype none

// ****************************************************************
// Load-store pipeline stand-in
// ****************************************************************
module csd_lsu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Decoded store from the decoder
    input wire logic outValid,
    input wire logic outIllegal,
    input wire logic outFault,
    input wire logic outMisaligned,
    // Tallies seen by the pipeline
    output logic [15:0] storeCount,
    output logic [15:0] trapCount
);
    timeunit 1ns;
    timeprecision 1ns;

    // Next tallies
    logic [15:0] next_storeCount;
    logic [15:0] next_trapCount;

    // A store only goes ahead when nothing traps; faults win over the write
    always_comb begin
        next_storeCount = storeCount;
        next_trapCount = trapCount;
        if (outValid && !outFault && !outMisaligned) begin
            next_storeCount = storeCount + 16'h0001;
        end else if (outValid || outIllegal) begin
            next_trapCount = trapCount + 16'h0001;
        end
    end

    // Tally registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            storeCount <= 16'h0000;
            trapCount <= 16'h0000;
        end else begin
            storeCount <= next_storeCount;
            trapCount <= next_trapCount;
        end
    end
endmodule : csd_lsu_model

`default_nettype wire

/* verif/csd_store_decode_tb.sv */
`default_nettype none

// ****************************************************************
// Decoder bench with reference model
// ****************************************************************
module csd_store_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // Design inputs
    logic clk, rst_b, instrValid, capMode, isRv64, extCompressed, extLegacy, extPurecap;
    logic [15:0] instr;
    logic regTag, regSealed, regPermWrite, spTag, spSealed, spPermWrite;
    logic ddcTag, ddcSealed, ddcPermWrite;
    logic [63:0] regCursor, regBase, regTop, spCursor, spBase, spTop, ddcBase, ddcTop;
    // Design outputs
    logic outValid, outIllegal, outFault, outMisaligned;
    csd_pkg::csd_kind_type outKind;
    csd_pkg::csd_auth_type outAuth;
    logic [63:0] outAddr;
    logic [4:0] outSize, outBaseReg, outSrcReg, outCause;
    logic [3:0] outFaultType;
    logic [15:0] storeCount, trapCount;
    // Expected values and bookkeeping
    csd_pkg::csd_kind_type eKind;
    csd_pkg::csd_auth_type eAuth;
    logic eV, eIll, eFault, eMis, have;
    logic [63:0] eAddr;
    logic [4:0] eSize, eBase, eSrc, eCause;
    int fail_count, checked, expStores, expTraps;

    csd_store_decode uut (.clk, .rst_b, .instrValid, .instr, .capMode, .isRv64,
        .extCompressed, .extLegacy, .extPurecap, .regTag, .regSealed, .regPermWrite,
        .regCursor, .regBase, .regTop, .spTag, .spSealed, .spPermWrite, .spCursor,
        .spBase, .spTop, .ddcTag, .ddcSealed, .ddcPermWrite, .ddcBase, .ddcTop,
        .outValid, .outIllegal, .outKind, .outAuth, .outAddr, .outSize, .outBaseReg,
        .outSrcReg, .outFault, .outCause, .outFaultType, .outMisaligned);

    csd_lsu_model lsu (.clk, .rst_b, .outValid, .outIllegal, .outFault, .outMisaligned,
        .storeCount, .trapCount);

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare one value and count it
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    // Scaled offset: 0 word, 1 doubleword, 2 capability layout on RV64
    function automatic logic [9:0] offOf(int form, logic [15:0] i);
        if (i[1:0] == 2'h0) begin
            case (form)
                0: return {3'h0, i[5], i[12:10], i[6], 2'h0};
                1: return {2'h0, i[6:5], i[12:10], 3'h0};
                default: return {1'h0, i[10], i[6:5], i[12:11], 4'h0};
            endcase
        end
        case (form)
            0: return {2'h0, i[8:7], i[12:9], 2'h0};
            1: return {1'h0, i[9:7], i[12:10], 3'h0};
            default: return {i[10:7], i[12:11], 4'h0};
        endcase
    endfunction : offOf

    // Reference decode of the inputs now on the pins
    task automatic model();
        logic q0, q2, t, s, p;
        logic [63:0] b, tp;
        int form;
        q0 = instr[1:0] == 2'h0;
        q2 = instr[1:0] == 2'h2;
        eKind = csd_pkg::CSD_KIND_NONE;
        eSize = 5'h00;
        form = 0;
        if (instrValid && extCompressed && (capMode ? extPurecap : extLegacy) && (q0 || q2)) begin
            case (instr[15:13])
                3'h6: begin
                    eKind = csd_pkg::CSD_KIND_SW;
                    eSize = 5'h04;
                end
                3'h7: begin
                    eKind = isRv64 ? csd_pkg::CSD_KIND_SD :
                        capMode ? csd_pkg::CSD_KIND_CSC : csd_pkg::CSD_KIND_FSW;
                    eSize = (isRv64 || capMode) ? 5'h08 : 5'h04;
                    form = isRv64 ? 1 : 0;
                end
                3'h5: begin
                    eKind = (isRv64 && capMode) ? csd_pkg::CSD_KIND_CSC : csd_pkg::CSD_KIND_FSD;
                    eSize = (isRv64 && capMode) ? 5'h10 : 5'h08;
                    form = (isRv64 && capMode) ? 2 : 1;
                end
                default: eSize = 5'h00;
            endcase
        end
        eV = eKind != csd_pkg::CSD_KIND_NONE;
        eIll = instrValid && !eV;
        eAuth = !capMode ? csd_pkg::CSD_AUTH_DDC :
            q0 ? csd_pkg::CSD_AUTH_REG : csd_pkg::CSD_AUTH_SP;
        eAddr = (q0 ? regCursor : spCursor) + 64'(offOf(form, instr));
        eBase = q0 ? 5'(8 + instr[9:7]) : 5'h02;
        eSrc = q0 ? 5'(8 + instr[4:2]) : instr[6:2];
        case (eAuth)
            csd_pkg::CSD_AUTH_REG:
                {t, s, p, b, tp} = {regTag, regSealed, regPermWrite, regBase, regTop};
            csd_pkg::CSD_AUTH_SP: {t, s, p, b, tp} = {spTag, spSealed, spPermWrite, spBase, spTop};
            default: {t, s, p, b, tp} = {ddcTag, ddcSealed, ddcPermWrite, ddcBase, ddcTop};
        endcase
        eCause = !eV ? 5'h00 : !t ? 5'h01 : s ? 5'h02 : !p ? 5'h03 :
            ({1'b0, eAddr} < {1'b0, b} || {1'b0, eAddr} + 65'(eSize) > {1'b0, tp}) ?
            5'h04 : 5'h00;
        eFault = eCause != 5'h00;
        eMis = eV && !eFault && eKind == csd_pkg::CSD_KIND_CSC &&
            (eAddr & 64'(eSize - 5'h01)) != 0;
    endtask : model

    // Rare event, one in eight
    function automatic logic rare();
        return $urandom % 8 == 0;
    endfunction : rare

    // Random instruction, mode and capabilities; quiet keeps instrValid low
    // Quiet matters on the edge that releases reset: the decoder flops are still
    // held there, but the checks already run and would see a request vanish
    task automatic drive(input logic quiet);
        logic [15:0] i;
        logic [63:0] c, sc;
        i = 16'($urandom);
        if (!rare()) i[1:0] = ($urandom % 2 != 0) ? 2'h2 : 2'h0;
        if (!rare()) i[15:13] = 3'(5 + $urandom % 3);
        c = {$urandom, $urandom};
        if ($urandom % 2 != 0) c[3:0] = 4'h0;
        sc = c + 64'(($urandom % 16) * 16);
        instr <= i;
        instrValid <= !quiet && !rare();
        {capMode, isRv64} <= 2'($urandom);
        {extCompressed, extLegacy, extPurecap} <= {!rare(), !rare(), !rare()};
        {regTag, regSealed, regPermWrite} <= {!rare(), rare(), !rare()};
        {spTag, spSealed, spPermWrite} <= {!rare(), rare(), !rare()};
        {ddcTag, ddcSealed, ddcPermWrite} <= {!rare(), rare(), !rare()};
        regCursor <= c;
        regBase <= c - 64'($urandom % 64);
        regTop <= c + 64'($urandom % 1100);
        spCursor <= sc;
        spBase <= sc - 64'($urandom % 64);
        spTop <= sc + 64'($urandom % 1100);
        ddcBase <= c - 64'($urandom % 512);
        ddcTop <= c + 64'($urandom % 1800);
    endtask : drive

    // Run bound: a hang counts as a mismatch
    initial begin
        #600000;
        fail_count++;
        $display("run bound exceeded");
        finish_test();
    end

    // Main sequence: reset, random decode, mid-run reset, random decode
    initial begin
        {rst_b, instrValid, instr} <= '0;
        {capMode, isRv64, extCompressed, extLegacy, extPurecap} <= '0;
        {regTag, regSealed, regPermWrite, spTag, spSealed, spPermWrite} <= '0;
        {ddcTag, ddcSealed, ddcPermWrite, regCursor, regBase, regTop} <= '0;
        {spCursor, spBase, spTop, ddcBase, ddcTop} <= '0;
        {fail_count, checked, expStores, expTraps, have} = '0;
        void'($urandom(32'hf7b5));
        for (int n = 0; n < 4000; n++) begin
            @(posedge clk);
            // Reset for 20 cycles, and again briefly in mid-run
            rst_b <= !(n < 20 || (n >= 2000 && n < 2004));
            drive(n < 20 || (n >= 2000 && n < 2004));
            @(negedge clk);
            if (!rst_b) begin
                check("outValid", 64'(outValid), 64'h0);
                check("outKind", 64'(outKind), 64'(csd_pkg::CSD_KIND_NONE));
                check("outAuth", 64'(outAuth), 64'(csd_pkg::CSD_AUTH_DDC));
                check("outCause", 64'(outCause), 64'h0);
                {expStores, expTraps} = '0;
            end else if (have) begin
                check("outValid", 64'(outValid), 64'(eV));
                check("outIllegal", 64'(outIllegal), 64'(eIll));
                check("outFault", 64'(outFault), 64'(eFault));
                check("outCause", 64'(outCause), 64'(eCause));
                check("outFaultType", 64'(outFaultType), 64'(eFault));
                check("outMisaligned", 64'(outMisaligned), 64'(eMis));
                if (eV) begin
                    check("outKind", 64'(outKind), 64'(eKind));
                    check("outAuth", 64'(outAuth), 64'(eAuth));
                    check("outAddr", outAddr, eAddr);
                    check("outSize", 64'(outSize), 64'(eSize));
                    check("outBaseReg", 64'(outBaseReg), 64'(eBase));
                    check("outSrcReg", 64'(outSrcReg), 64'(eSrc));
                end
                expStores += int'(eV && !eFault && !eMis);
                expTraps += int'((eV && (eFault || eMis)) || eIll);
            end
            have = rst_b;
            model();
            if (n == 1999) $display("first random decode test ended");
        end
        @(posedge clk);
        #1;
        check("storeCount", 64'(storeCount), 64'(expStores));
        check("trapCount", 64'(trapCount), 64'(expTraps));
        $display("second random decode test ended");
        finish_test();
    end
endmodule : csd_store_decode_tb

`default_nettype wire
